// ===== inc/lsg_pkg.sv
// Purpose: shared constants for the luma sharpness/gamma filter block
// Assumes: 32-bit AXI4-Lite register bus, 8-bit registers in low bits
// Notes: register index times four gives the byte address
package lsg_pkg;
  // register indices as printed; byte address is index * 4
  localparam logic [7:0] IDX_PLL_SETUP = 8'h09;
  localparam logic [7:0] IDX_GAIN_PAIR = 8'h10;
  localparam logic [7:0] IDX_CP_LOW = 8'h11;
  localparam logic [7:0] IDX_CP_MID = 8'h12;
  localparam logic [7:0] IDX_CP_HIGH = 8'h13;
  localparam logic [7:0] IDX_GAMMA_FIRST = 8'h14;
  localparam logic [7:0] IDX_GAMMA_LAST = 8'h21;
  localparam logic [7:0] IDX_EDGE_GAIN_S = 8'h22;
  localparam logic [7:0] IDX_EDGE_GAIN_M = 8'h23;
  localparam logic [7:0] IDX_EDGE_GAIN_L = 8'h24;
  localparam logic [7:0] IDX_THR_S = 8'h25;
  localparam logic [7:0] IDX_THR_M = 8'h26;
  localparam logic [7:0] IDX_THR_L = 8'h27;
  localparam logic [7:0] IDX_CTRL = 8'h28;
  localparam logic [7:0] IDX_STATUS = 8'h29;
  // control register bit positions
  localparam int CTRL_SHARP_EN = 0;
  localparam int CTRL_ADAPT_EN = 1;
  localparam int CTRL_SUBMODE = 2;
  localparam int CTRL_CURVE_SEL = 3;
  localparam int CTRL_GAMMA_EN = 4;
  localparam int CTRL_CP_EN = 5;
  localparam int CTRL_INTERP_EN = 6;
  localparam int CTRL_WIDTH = 7;
  // reset values and fixed figures
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] PLL_SETUP_VALUE = 8'h3E;
  localparam logic [3:0] CP_HIGH_MASK = 4'hF;
  localparam int GAMMA_POINTS = 14;
  localparam int CURVE_POINTS = 7;
  // fixed curve anchors (input 0,16,240,255 pass through)
  localparam logic [7:0] GAMMA_LO_IN = 8'h10;
  localparam logic [7:0] GAMMA_HI_IN = 8'hF0;
  // gain A used when the adaptive sub-mode is the single-filter one
  localparam logic [3:0] FIXED_GAIN_A = 4'h0;
  // copy-protection insertion line
  localparam logic [9:0] CP_LINE = 10'h029;
  // axi response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    LSG_BAND_BASE,
    LSG_BAND_SMALL,
    LSG_BAND_MEDIUM,
    LSG_BAND_LARGE
  } lsg_band_e;
endpackage : lsg_pkg

// ===== src/lsg_filter.sv
// Purpose: luma sharpness, adaptive edge and gamma datapath with registers
// Assumes: aclk is the pixel clock; one luma sample per cycle when valid
// Notes: registers over AXI4-Lite; 8-bit data in low bits, rest read zero
//
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
module lsg_filter
  import lsg_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic pix_valid,
  input wire logic [7:0] luma_in,
  input wire logic [7:0] cr_in,
  input wire logic [7:0] cb_in,
  input wire logic [9:0] line_num,
  output logic pix_valid_out,
  output logic [7:0] luma_out,
  output logic [7:0] cr_out,
  output logic [7:0] cb_out,
  output logic cp_insert,
  output logic [19:0] cp_word,
  output logic interp_en
);
  // register storage
  logic [7:0] pll_setup_r, gain_pair_r, cp_low_r, cp_mid_r;
  logic [3:0] cp_high_r;
  logic [7:0] gamma_r [GAMMA_POINTS];
  logic [7:0] edge_gain_r [3];
  logic [7:0] thr_r [3];
  logic [CTRL_WIDTH-1:0] ctrl_r;
  logic [7:0] wr_idx_r;
  logic aw_held_r, w_held_r;
  logic [7:0] w_data_r;
  logic w_lane_r;

  // word index from byte address
  function automatic logic [7:0] word_idx(input logic [31:0] a);
    return a[9:2];
  endfunction : word_idx

  // decode of a mapped index, used for read and write
  function automatic logic mapped(input logic [7:0] i);
    return (i == IDX_PLL_SETUP) || (i >= IDX_GAIN_PAIR && i <= IDX_STATUS);
  endfunction : mapped

  // write channel capture: address and data taken in either order
  logic wr_go;
  assign wr_go = aw_held_r && w_held_r && !s_axi_bvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      wr_idx_r <= 8'h00;
      w_data_r <= 8'h00;
      w_lane_r <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready <= !w_held_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        wr_idx_r <= word_idx(s_axi_awaddr);
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        w_data_r <= s_axi_wdata[7:0];
        w_lane_r <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        aw_held_r <= 1'b0;
        w_held_r <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(wr_idx_r) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes; only byte lane 0 carries data
  logic do_wr;
  assign do_wr = wr_go && w_lane_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pll_setup_r <= REG_RESET;
      gain_pair_r <= REG_RESET;
      cp_low_r <= REG_RESET;
      cp_mid_r <= REG_RESET;
      cp_high_r <= 4'h0;
      ctrl_r <= '0;
      for (int i = 0; i < GAMMA_POINTS; i++) gamma_r[i] <= REG_RESET;
      for (int i = 0; i < 3; i++) begin
        edge_gain_r[i] <= REG_RESET;
        thr_r[i] <= REG_RESET;
      end
    end else if (do_wr) begin
      case (wr_idx_r)
        IDX_PLL_SETUP: pll_setup_r <= w_data_r;
        IDX_GAIN_PAIR: gain_pair_r <= w_data_r;
        IDX_CP_LOW: cp_low_r <= w_data_r;
        IDX_CP_MID: cp_mid_r <= w_data_r;
        IDX_CP_HIGH: cp_high_r <= w_data_r[3:0] & CP_HIGH_MASK;
        IDX_CTRL: ctrl_r <= w_data_r[CTRL_WIDTH-1:0];
        default: begin
          if (wr_idx_r >= IDX_GAMMA_FIRST && wr_idx_r <= IDX_GAMMA_LAST)
            gamma_r[4'(wr_idx_r - IDX_GAMMA_FIRST)] <= w_data_r;
          else if (wr_idx_r >= IDX_EDGE_GAIN_S && wr_idx_r <= IDX_EDGE_GAIN_L)
            edge_gain_r[2'(wr_idx_r - IDX_EDGE_GAIN_S)] <= w_data_r;
          else if (wr_idx_r >= IDX_THR_S && wr_idx_r <= IDX_THR_L)
            thr_r[2'(wr_idx_r - IDX_THR_S)] <= w_data_r;
        end
      endcase
    end
  end

  // interpolation enable is gated until the pll setup value is present
  always_ff @(posedge aclk) begin
    if (!aresetn) interp_en <= 1'b0;
    else interp_en <= ctrl_r[CTRL_INTERP_EN] &&
                      pll_setup_r == PLL_SETUP_VALUE;
  end

  // read channel: one cycle after the address is taken
  logic [7:0] rd_val;
  lsg_band_e band_r;
  always_comb begin
    rd_val = 8'h00;
    case (word_idx(s_axi_araddr))
      IDX_PLL_SETUP: rd_val = pll_setup_r;
      IDX_GAIN_PAIR: rd_val = gain_pair_r;
      IDX_CP_LOW: rd_val = cp_low_r;
      IDX_CP_MID: rd_val = cp_mid_r;
      IDX_CP_HIGH: rd_val = {4'h0, cp_high_r};
      IDX_CTRL: rd_val = {1'b0, ctrl_r};
      IDX_STATUS: rd_val = {6'h00, band_r};
      default: begin
        if (word_idx(s_axi_araddr) >= IDX_GAMMA_FIRST &&
            word_idx(s_axi_araddr) <= IDX_GAMMA_LAST)
          rd_val = gamma_r[4'(word_idx(s_axi_araddr) - IDX_GAMMA_FIRST)];
        else if (word_idx(s_axi_araddr) >= IDX_EDGE_GAIN_S &&
                 word_idx(s_axi_araddr) <= IDX_EDGE_GAIN_L)
          rd_val = edge_gain_r[2'(word_idx(s_axi_araddr) - IDX_EDGE_GAIN_S)];
        else if (word_idx(s_axi_araddr) >= IDX_THR_S &&
                 word_idx(s_axi_araddr) <= IDX_THR_L)
          rd_val = thr_r[2'(word_idx(s_axi_araddr) - IDX_THR_S)];
      end
    endcase
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h00_0000, rd_val};
        s_axi_rresp <= mapped(word_idx(s_axi_araddr)) ? RESP_OKAY
                                                     : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // stage 1: registered absolute derivative of neighbouring luma
  logic [7:0] luma_prev_r, deriv_r, luma1_r, luma2_r, cr1_r, cb1_r;
  logic [7:0] cr2_r, cb2_r, luma_old_r;
  logic v1_r, v2_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      luma_prev_r <= 8'h00;
      deriv_r <= 8'h00;
      luma1_r <= 8'h00;
      luma_old_r <= 8'h00;
      cr1_r <= 8'h00;
      cb1_r <= 8'h00;
      v1_r <= 1'b0;
    end else begin
      v1_r <= pix_valid;
      if (pix_valid) begin
        luma_prev_r <= luma_in;
        luma1_r <= luma_in;
        luma_old_r <= luma1_r; // sample before luma1_r, for the high-pass
        cr1_r <= cr_in;
        cb1_r <= cb_in;
        deriv_r <= (luma_in > luma_prev_r) ? luma_in - luma_prev_r
                                           : luma_prev_r - luma_in;
      end
    end
  end

  // band select: derivative against thresholds, C over B over A
  lsg_band_e band;
  logic adapt_on;
  assign adapt_on = ctrl_r[CTRL_SHARP_EN] && ctrl_r[CTRL_ADAPT_EN];
  always_comb begin
    band = LSG_BAND_BASE;
    if (adapt_on) begin
      if (deriv_r > thr_r[2]) band = LSG_BAND_LARGE;
      else if (deriv_r > thr_r[1]) band = LSG_BAND_MEDIUM;
      else if (deriv_r > thr_r[0]) band = LSG_BAND_SMALL;
    end
  end

  // one gain register active; low nibble fixed when adaptive and not cascaded
  logic [7:0] gsel;
  logic signed [3:0] gain_a, gain_b;
  always_comb begin
    case (band)
      LSG_BAND_SMALL: gsel = edge_gain_r[0];
      LSG_BAND_MEDIUM: gsel = edge_gain_r[1];
      LSG_BAND_LARGE: gsel = edge_gain_r[2];
      default: gsel = gain_pair_r;
    endcase
    gain_b = gsel[7:4];
    gain_a = gsel[3:0];
    if (adapt_on && !ctrl_r[CTRL_SUBMODE])
      gain_a = FIXED_GAIN_A;
  end

  // stage 2: filter A (high-pass) and filter B (band term) scaled by gains
  logic signed [10:0] hp, lp;
  logic signed [14:0] acc;
  logic [7:0] sharp_y;
  always_comb begin
    hp = 11'(signed'({3'b000, luma1_r})) -
         11'(signed'({3'b000, luma_old_r}));
    lp = 11'(signed'({3'b000, deriv_r}));
    acc = 15'(signed'({3'b000, luma1_r})) <<< 3;
    if (ctrl_r[CTRL_SHARP_EN]) begin
      if (!adapt_on || ctrl_r[CTRL_SUBMODE])
        acc = acc + 15'(hp) * 15'(gain_a);
      acc = acc + 15'(hp) * 15'(gain_b) - ((15'(lp) * 15'(gain_b)) >>> 2);
    end
    acc = acc >>> 3;
    sharp_y = acc < 0 ? 8'h00 : (acc > 15'sd255 ? 8'hFF : acc[7:0]);
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      luma2_r <= 8'h00;
      cr2_r <= 8'h00;
      cb2_r <= 8'h00;
      v2_r <= 1'b0;
      band_r <= LSG_BAND_BASE;
    end else begin
      v2_r <= v1_r;
      band_r <= band;
      luma2_r <= sharp_y;
      cr2_r <= cr1_r;
      cb2_r <= cb1_r;
    end
  end

  // stage 3: gamma by piecewise linear interpolation
  logic [7:0] gy, x0, y0, y1;
  logic [8:0] span;
  logic [16:0] prod;
  logic [2:0] seg;
  always_comb begin
    seg = luma2_r[7:5];
    x0 = {seg, 5'b0_0000};
    y0 = (seg == 3'd0) ? GAMMA_LO_IN :
         gamma_r[{ctrl_r[CTRL_CURVE_SEL] ? 4'd7 : 4'd0} + 4'(seg - 3'd1)];
    y1 = (seg == 3'd7) ? GAMMA_HI_IN :
         gamma_r[{ctrl_r[CTRL_CURVE_SEL] ? 4'd7 : 4'd0} + 4'(seg)];
    span = (seg == 3'd0) ? 9'd16 : ((seg == 3'd7) ? 9'd16 : 9'd32);
    if (seg == 3'd0) x0 = GAMMA_LO_IN;
    prod = 17'(signed'({1'b0, y1}) - signed'({1'b0, y0})) *
           17'(luma2_r - x0);
    gy = 8'(9'(y0) + 9'(signed'(prod) / signed'(17'(span))));
    if (luma2_r <= GAMMA_LO_IN || luma2_r >= GAMMA_HI_IN)
      gy = luma2_r;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      luma_out <= 8'h00;
      cr_out <= 8'h00;
      cb_out <= 8'h00;
      pix_valid_out <= 1'b0;
    end else begin
      pix_valid_out <= v2_r;
      luma_out <= ctrl_r[CTRL_GAMMA_EN] ? gy : luma2_r;
      cr_out <= cr2_r;
      cb_out <= cb2_r;
    end
  end

  // copy-protect word on its line
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cp_insert <= 1'b0;
      cp_word <= 20'h0_0000;
    end else begin
      cp_insert <= ctrl_r[CTRL_CP_EN] && line_num == CP_LINE;
      cp_word <= {cp_high_r, cp_mid_r, cp_low_r};
    end
  end

  // checks
  property p_cp_line;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_r[CTRL_CP_EN] && line_num == CP_LINE) |=> cp_insert;
  endproperty
  a_cp_line: assert property (p_cp_line) else $error("cp not inserted");
  property p_band_large;
    @(posedge aclk) disable iff (!aresetn)
      (adapt_on && deriv_r > thr_r[2]) |=> band_r == LSG_BAND_LARGE;
  endproperty
  a_band_large: assert property (p_band_large) else $error("band C");
  property p_band_base;
    @(posedge aclk) disable iff (!aresetn)
      !adapt_on |=> band_r == LSG_BAND_BASE;
  endproperty
  a_band_base: assert property (p_band_base) else $error("band base");
  property p_chroma;
    @(posedge aclk) disable iff (!aresetn)
      v1_r |=> ##1 cr_out == $past(cr1_r, 2);
  endproperty
  a_chroma: assert property (p_chroma) else $error("chroma changed");
  property p_bypass;
    @(posedge aclk) disable iff (!aresetn)
      !ctrl_r[CTRL_GAMMA_EN] |=> luma_out == $past(luma2_r);
  endproperty
  a_bypass: assert property (p_bypass) else $error("no bypass");
  property p_fixed;
    @(posedge aclk) disable iff (!aresetn)
      luma2_r >= GAMMA_HI_IN |=> luma_out == $past(luma2_r);
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed point");
  property p_cp_high;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready &&
       word_idx(s_axi_araddr) == IDX_CP_HIGH) |=> s_axi_rdata[7:4] == 4'h0;
  endproperty
  a_cp_high: assert property (p_cp_high) else $error("upper bits");
  property p_wresp;
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid;
  endproperty
  a_wresp: assert property (p_wresp) else $error("bresp");
  c_adapt: cover property (@(posedge aclk) band_r == LSG_BAND_MEDIUM);
  c_gamma: cover property (@(posedge aclk) ctrl_r[CTRL_GAMMA_EN] && v2_r);
  c_cp: cover property (@(posedge aclk) cp_insert);
endmodule : lsg_filter

// ===== verification/lsg_filter_tb.sv
// Purpose: self-checking bench for registers, gamma, edge bands, side outputs
// Assumes: aclk 100 ns, aresetn low for six cycles, filter shapes unchecked
// Notes: luma is compared with sharpness off, or on flat luma only
`timescale 1ns/1ns
module luma_sharpness_gamma_filter_tb_top;
  import lsg_pkg::*;
  logic aclk, aresetn;
  logic [31:0] awaddr, wdata, araddr, rdata, rd;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pv, pvo, cpi, itp, src_alt;
  logic [1:0] bresp, rresp, rs;
  logic [7:0] y, cr, cb, yo, cro, cbo, src_b, src_s;
  logic [9:0] line;
  logic [19:0] cpw;
  int fail_count, check_count;
  logic [7:0] g_in [9] = '{0, 16, 24, 32, 48, 232, 240, 248, 255};
  logic [7:0] g_a [9] = '{0, 16, 28, 40, 56, 236, 240, 248, 255};
  logic [7:0] g_b [9] = '{0, 16, 20, 24, 40, 228, 240, 248, 255};

  lsg_filter dut_u (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pix_valid(pv),
    .luma_in(y), .cr_in(cr), .cb_in(cb), .line_num(line),
    .pix_valid_out(pvo), .luma_out(yo), .cr_out(cro), .cb_out(cbo),
    .cp_insert(cpi), .cp_word(cpw), .interp_en(itp));

  lsg_video_src src_u (.aclk(aclk), .aresetn(aresetn), .base_lvl(src_b),
    .step_lvl(src_s), .alt_en(src_alt), .pix_valid(pv), .luma_in(y),
    .cr_in(cr), .cb_in(cb));

  // free-running pixel clock
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  task automatic conclude();
    if (fail_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk

  // one write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    r = 2'b11;
    @(posedge aclk);
    awaddr <= {22'h0, idx, 2'b00};
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (n < 60) begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) chk(32'h1, 32'h0, "write hang");
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    r = 2'b11;
    d = 32'h0;
    @(posedge aclk);
    araddr <= {22'h0, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (n < 60) begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        r = rresp;
        d = rdata;
        rready <= 1'b0;
        n = 99;
      end
    end
    if (n != 99) chk(32'h1, 32'h0, "read hang");
  endtask : axi_rd

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    axi_wr(idx, d, rs);
    chk(32'(rs), 32'(RESP_OKAY), "write resp");
  endtask : wr

  task automatic rd_chk(input logic [7:0] idx, input logic [31:0] exp);
    axi_rd(idx, rd, rs);
    chk(32'(rs), 32'(RESP_OKAY), "read resp");
    chk(rd, exp, "read data");
  endtask : rd_chk

  // flat luma in, compare all three channels after the pipeline settles
  task automatic lu_chk(input logic [7:0] x, input logic [7:0] ey);
    src_b <= x;
    src_alt <= 1'b0;
    repeat (8) @(posedge aclk);
    chk(32'(pvo), 32'h1, "valid out");
    chk(32'(yo), 32'(ey), "luma");
    chk(32'(cro), 32'(x ^ 8'h5A), "cr");
    chk(32'(cbo), 32'(8'(~x)), "cb");
  endtask : lu_chk

  task automatic band_chk(input logic [7:0] s, input lsg_band_e b);
    src_b <= 8'h40;
    src_s <= s;
    src_alt <= 1'b1;
    repeat (8) @(posedge aclk);
    axi_rd(IDX_STATUS, rd, rs);
    chk(32'(rd[1:0]), 32'(b), "band");
  endtask : band_chk

  task automatic thr(input logic [7:0] a, input logic [7:0] b,
                     input logic [7:0] c);
    wr(IDX_THR_S, 32'(a));
    wr(IDX_THR_M, 32'(b));
    wr(IDX_THR_L, 32'(c));
  endtask : thr

  // cut a hang short
  initial begin
    #3_000_000;
    fail_count++;
    conclude();
  end

  initial begin
    fail_count = 0;
    check_count = 0;
    aresetn = 1'b0;
    {awaddr, wdata, araddr} = '0;
    {awvalid, wvalid, bready, arvalid, rready, src_alt} = '0;
    src_b = 8'h00;
    src_s = 8'h00;
    line = 10'h000;
    repeat (6) @(posedge aclk);
    chk(32'({cpi, itp, pvo}), 32'h0, "reset outputs");
    aresetn <= 1'b1;
    rd_chk(IDX_GAIN_PAIR, 32'(REG_RESET));
    rd_chk(IDX_CP_HIGH, 32'(REG_RESET));
    rd_chk(IDX_CTRL, 32'(REG_RESET));
    // curve A sits 8 above the diagonal, curve B 8 below
    for (int i = 0; i < 14; i++) begin
      wr(IDX_GAMMA_FIRST + 8'(i),
         i < 7 ? 32'(32 * i + 40) : 32'(32 * i - 200));
    end
    for (int i = 0; i < 14; i++) begin
      rd_chk(IDX_GAMMA_FIRST + 8'(i),
             i < 7 ? 32'(32 * i + 40) : 32'(32 * i - 200));
    end
    wr(IDX_GAIN_PAIR, 32'h99);
    rd_chk(IDX_GAIN_PAIR, 32'h99);
    wr(IDX_EDGE_GAIN_S, 32'hAC);
    wr(IDX_EDGE_GAIN_M, 32'h9A);
    wr(IDX_EDGE_GAIN_L, 32'h88);
    rd_chk(IDX_EDGE_GAIN_S, 32'hAC);
    rd_chk(IDX_EDGE_GAIN_M, 32'h9A);
    rd_chk(IDX_EDGE_GAIN_L, 32'h88);
    // unmapped place answers with an error and reads zero
    axi_rd(8'h30, rd, rs);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped read");
    chk(rd, 32'h0, "unmapped data");
    axi_wr(8'h30, 32'h55, rs);
    chk(32'(rs), 32'(RESP_SLVERR), "unmapped write");
    // copy-protection word and its insertion line
    wr(IDX_CP_LOW, 32'hA5);
    wr(IDX_CP_MID, 32'h3C);
    wr(IDX_CP_HIGH, 32'h0F);
    rd_chk(IDX_CP_HIGH, 32'h0F);
    wr(IDX_CP_HIGH, 32'h09);
    // pll setup value goes in before the interpolation bit is set
    wr(IDX_PLL_SETUP, 32'(PLL_SETUP_VALUE));
    chk(32'(itp), 32'h0, "interp early");
    wr(IDX_CTRL, 32'(1 << CTRL_CP_EN) | 32'(1 << CTRL_INTERP_EN));
    line <= CP_LINE;
    repeat (3) @(posedge aclk);
    chk(32'(cpi), 32'h1, "cp insert");
    chk(32'(cpw), 32'h9_3CA5, "cp word");
    chk(32'(itp), 32'h1, "interp on");
    line <= CP_LINE - 10'h001;
    repeat (3) @(posedge aclk);
    chk(32'(cpi), 32'h0, "cp off line");
    // both curves, fixed anchors and interpolated midpoints
    for (int c = 0; c < 2; c++) begin
      wr(IDX_CTRL, 32'(1 << CTRL_GAMMA_EN) | 32'(c << CTRL_CURVE_SEL));
      for (int k = 0; k < 9; k++) begin
        lu_chk(g_in[k], c ? g_b[k] : g_a[k]);
      end
    end
    wr(IDX_CTRL, 32'h0);
    lu_chk(8'd48, 8'd48);
    lu_chk(8'd232, 8'd232);
    // flat luma passes the sharpness path unchanged
    wr(IDX_CTRL, 32'(1 << CTRL_SHARP_EN));
    lu_chk(8'd100, 8'd100);
    // edge bands; strict greater-than on every threshold
    wr(IDX_CTRL, 32'(1 << CTRL_SHARP_EN) | 32'(1 << CTRL_ADAPT_EN));
    thr(8'h28, 8'h3F, 8'h64);
    band_chk(8'h28, LSG_BAND_BASE);
    band_chk(8'h29, LSG_BAND_SMALL);
    band_chk(8'h3F, LSG_BAND_SMALL);
    band_chk(8'h40, LSG_BAND_MEDIUM);
    band_chk(8'h64, LSG_BAND_MEDIUM);
    band_chk(8'h65, LSG_BAND_LARGE);
    thr(8'h10, 8'h50, 8'h30);
    band_chk(8'h40, LSG_BAND_LARGE);
    band_chk(8'h20, LSG_BAND_SMALL);
    thr(8'h00, 8'hFF, 8'hFF);
    band_chk(8'h01, LSG_BAND_SMALL);
    band_chk(8'h00, LSG_BAND_BASE);
    lu_chk(8'd90, 8'd90);
    wr(IDX_CTRL, 32'(1 << CTRL_SHARP_EN) | 32'(1 << CTRL_ADAPT_EN) |
       32'(1 << CTRL_SUBMODE));
    lu_chk(8'd90, 8'd90);
    conclude();
  end
endmodule : luma_sharpness_gamma_filter_tb_top

// ===== verification/lsg_video_src.sv
// Purpose: video source model feeding luma and colour samples
// Assumes: one sample per clock, valid held high once out of reset
// Notes: step mode alternates two levels so neighbours differ by step_lvl
`timescale 1ns/1ns
module lsg_video_src (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] base_lvl,
  input wire logic [7:0] step_lvl,
  input wire logic alt_en,
  output logic pix_valid,
  output logic [7:0] luma_in,
  output logic [7:0] cr_in,
  output logic [7:0] cb_in
);
  logic phase_r;
  logic [7:0] lvl;

  // next luma level: flat, or a square wave of height step_lvl
  assign lvl = (alt_en && phase_r) ? base_lvl + step_lvl : base_lvl;

  // colour follows luma through fixed maps so its path can be checked
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase_r <= 1'b0;
      pix_valid <= 1'b0;
      luma_in <= 8'h00;
      cr_in <= 8'h5A;
      cb_in <= 8'hFF;
    end else begin
      phase_r <= ~phase_r;
      pix_valid <= 1'b1;
      luma_in <= lvl;
      cr_in <= lvl ^ 8'h5A;
      cb_in <= ~lvl;
    end
  end
endmodule : lsg_video_src
